// ### rtl/szbt_defines.vh
// Constants for the static zone bus timing block.
// Assumes inclusion by bare name from the design files.
`ifndef SZBT_DEFINES_VH
`define SZBT_DEFINES_VH

// ****************************************
// Register indices on the plain port
// ****************************************
`define SZBT_OFS_ZONE0      3'h0
`define SZBT_OFS_ZONE1      3'h1
`define SZBT_OFS_ZONE2      3'h2
`define SZBT_OFS_IOZONE     3'h3
`define SZBT_OFS_CTRL       3'h4
`define SZBT_OFS_STATUS     3'h5

// ****************************************
// Reset values
// ****************************************
`define SZBT_CFG_RESET      16'h069F
`define SZBT_CTRL_RESET     1'h0

// ****************************************
// Configuration word fields
// ****************************************
`define SZBT_WAIT_LSB       0
`define SZBT_WAIT_MSB       2
`define SZBT_HOLD_LSB       3
`define SZBT_HOLD_MSB       4
`define SZBT_BURST_EN_BIT   5
`define SZBT_BURST_WAIT_BIT 6
`define SZBT_WIDTH_BIT      7
`define SZBT_POST_IDLE_BIT  9
`define SZBT_PRE_IDLE_BIT   10
`define SZBT_FAST_RD_BIT    11
`define SZBT_CFG_MASK       16'h0EFF

// ****************************************
// Zone codes
// ****************************************
`define SZBT_Z_FLASH        3'h0
`define SZBT_Z_ONE          3'h1
`define SZBT_Z_TWO          3'h2
`define SZBT_Z_IO           3'h3
`define SZBT_Z_PERIPH       3'h4
`define SZBT_Z_RAM          3'h5
`define SZBT_Z_NONE         3'h6

// ****************************************
// Address ranges
// ****************************************
`define SZBT_FLASH_HI       24'h03FFFF
`define SZBT_FDATA_LO       24'h0E0000
`define SZBT_FDATA_HI       24'h0E1FFF
`define SZBT_RAM0_LO        24'h0E8000
`define SZBT_RAM0_HI        24'h0E91FF
`define SZBT_RAM1_LO        24'h0EC000
`define SZBT_RAM1_HI        24'h0EEBFF
`define SZBT_PER0_LO        24'h0EF000
`define SZBT_PER0_HI        24'h0EF1FF
`define SZBT_PER1_LO        24'hFF0000
`define SZBT_PER1_HI        24'hFFFBFF
`define SZBT_IO_LO          24'hFFFB00
`define SZBT_IO_HI          24'hFFFBFF
`define SZBT_ZONE1_LO       24'h100000
`define SZBT_ZONE1_HI       24'h7FFFFF
`define SZBT_ZONE2_LO       24'h800000
`define SZBT_ZONE2_HI       24'hDFFFFF

// ****************************************
// Fixed timing counts in cycles
// ****************************************
`define SZBT_PER_WAITS      4'h1
`define SZBT_PER_IDLE       2'h1
`define SZBT_FWR_WAITS      4'h1

`endif

// ### rtl/szbt_cycle_counter.v
// Loadable down counter used to time one bus phase.
// Assumes a synchronised active-low reset from the parent.
`timescale 1ns/1ps

module szbt_cycle_counter #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input  wire             clk_sys,
	input  wire             rstSync_n,
	// Control
	input  wire             load,
	input  wire [WIDTH-1:0] loadValue,
	// Status
	output wire             last
);

	reg [WIDTH-1:0] count_reg;

	// Last phase cycle when one or none remain
	assign last = (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1});

	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			count_reg <= {WIDTH{1'b0}};
		end else if (load) begin
			count_reg <= loadValue;
		end else if (count_reg != {WIDTH{1'b0}}) begin
			count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

// ### rtl/szbt_bus_timing.v
// Static zone bus timing sequencer with its configuration words.
// Assumes a CPU master that issues one request and waits for cpuDone.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "szbt_defines.vh"

module szbt_bus_timing (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// Register port
	input  wire [2:0]  regAddr,
	input  wire [15:0] regWrData,
	input  wire        regWrite,
	input  wire        regRead,
	output wire [15:0] regRdData,
	// CPU bus request
	input  wire        cpuReq,
	input  wire [23:0] cpuAddr,
	input  wire        cpuWrite,
	input  wire        cpuWord,
	output wire        cpuBusy,
	output wire        cpuDone,
	// Zone selects and bus phase
	output wire        zone1Select,
	output wire        zone2Select,
	output wire        busWidth16,
	output wire        phaseIdle,
	output wire        phaseAccess,
	output wire        phaseWait,
	output wire        phaseBurst,
	output wire        phaseHold
);

	// ****************************************
	// States
	// ****************************************
	localparam [5:0] S_IDLE  = 6'h01;
	localparam [5:0] S_PRE   = 6'h02;
	localparam [5:0] S_ACC   = 6'h04;
	localparam [5:0] S_WAIT  = 6'h08;
	localparam [5:0] S_BURST = 6'h10;
	localparam [5:0] S_HOLD  = 6'h20;

	// ****************************************
	// Reset release
	// ****************************************
	reg rstMeta_reg;
	reg rstSync_n;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_reg <= 1'b0;
			rstSync_n   <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_n   <= rstMeta_reg;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	reg [15:0] zone0Cfg_reg;
	reg [15:0] zone1Cfg_reg;
	reg [15:0] zone2Cfg_reg;
	reg [15:0] io_zone_timing_config_reg;
	reg        earlyWrite_reg;
	reg [15:0] rdData_reg;
	reg [5:0]  state_reg;
	reg [2:0]  lastZone_reg;
	reg [15:0] rdData_next;

	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			zone0Cfg_reg   <= `SZBT_CFG_RESET;
			zone1Cfg_reg   <= `SZBT_CFG_RESET;
			zone2Cfg_reg   <= `SZBT_CFG_RESET;
			io_zone_timing_config_reg      <= `SZBT_CFG_RESET;
			earlyWrite_reg <= `SZBT_CTRL_RESET;
		end else if (regWrite) begin
			case (regAddr)
				`SZBT_OFS_ZONE0:  zone0Cfg_reg <= regWrData & `SZBT_CFG_MASK;
				`SZBT_OFS_ZONE1:  zone1Cfg_reg <= regWrData & `SZBT_CFG_MASK;
				`SZBT_OFS_ZONE2:  zone2Cfg_reg <= regWrData & `SZBT_CFG_MASK;
				`SZBT_OFS_IOZONE: io_zone_timing_config_reg <= regWrData & `SZBT_CFG_MASK;
				`SZBT_OFS_CTRL:   earlyWrite_reg <= regWrData[0];
				default: begin
				end
			endcase
		end
	end

	always @* begin
		case (regAddr)
			`SZBT_OFS_ZONE0:  rdData_next = zone0Cfg_reg;
			`SZBT_OFS_ZONE1:  rdData_next = zone1Cfg_reg;
			`SZBT_OFS_ZONE2:  rdData_next = zone2Cfg_reg;
			`SZBT_OFS_IOZONE: rdData_next = io_zone_timing_config_reg;
			`SZBT_OFS_CTRL:   rdData_next = {15'h0000, earlyWrite_reg};
			`SZBT_OFS_STATUS: rdData_next = {7'h00, lastZone_reg, state_reg};
			default:          rdData_next = 16'h0000;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			rdData_reg <= 16'h0000;
		end else begin
			rdData_reg <= regRead ? rdData_next : 16'h0000;
		end
	end

	// ****************************************
	// Address decode
	// ****************************************
	reg [2:0] decZone;

	always @* begin
		if (cpuAddr <= `SZBT_FLASH_HI ||
		    (cpuAddr >= `SZBT_FDATA_LO && cpuAddr <= `SZBT_FDATA_HI)) begin
			decZone = `SZBT_Z_FLASH;
		end else if ((cpuAddr >= `SZBT_RAM0_LO && cpuAddr <= `SZBT_RAM0_HI) ||
		             (cpuAddr >= `SZBT_RAM1_LO && cpuAddr <= `SZBT_RAM1_HI)) begin
			decZone = `SZBT_Z_RAM;
		end else if (cpuAddr >= `SZBT_IO_LO && cpuAddr <= `SZBT_IO_HI) begin
			decZone = `SZBT_Z_IO;
		end else if ((cpuAddr >= `SZBT_PER0_LO && cpuAddr <= `SZBT_PER0_HI) ||
		             (cpuAddr >= `SZBT_PER1_LO && cpuAddr <= `SZBT_PER1_HI)) begin
			decZone = `SZBT_Z_PERIPH;
		end else if (cpuAddr >= `SZBT_ZONE1_LO && cpuAddr <= `SZBT_ZONE1_HI) begin
			decZone = `SZBT_Z_ONE;
		end else if (cpuAddr >= `SZBT_ZONE2_LO && cpuAddr <= `SZBT_ZONE2_HI) begin
			decZone = `SZBT_Z_TWO;
		end else begin
			decZone = `SZBT_Z_NONE;
		end
	end

	// ****************************************
	// Timing of the requested cycle
	// ****************************************
	reg [15:0] decCfg;
	reg        decFast;
	reg        decWide;
	reg        decTwo;
	reg        decBurst;
	reg        decBurstWait;
	reg [3:0]  decWaits;
	reg [1:0]  decHold;
	reg [1:0]  decIdle;
	reg        decPost;
	reg        prevPost_reg;

	always @* begin
		case (decZone)
			`SZBT_Z_FLASH: decCfg = zone0Cfg_reg;
			`SZBT_Z_ONE:   decCfg = zone1Cfg_reg;
			`SZBT_Z_TWO:   decCfg = zone2Cfg_reg;
			`SZBT_Z_IO:    decCfg = io_zone_timing_config_reg;
			default:       decCfg = 16'h0000;
		endcase
		decFast = decCfg[`SZBT_FAST_RD_BIT];
		decWide = decCfg[`SZBT_WIDTH_BIT] || decZone == `SZBT_Z_FLASH ||
		          decZone == `SZBT_Z_PERIPH || decZone == `SZBT_Z_RAM ||
		          decZone == `SZBT_Z_NONE;
		decTwo = cpuWord && !decWide;
		decBurst = decTwo && !cpuWrite && decCfg[`SZBT_BURST_EN_BIT] && !decFast;
		decBurstWait = decBurst && decCfg[`SZBT_BURST_WAIT_BIT];
		decWaits = 4'h0;
		decHold = 2'h0;
		decPost = decCfg[`SZBT_POST_IDLE_BIT];
		decIdle = 2'h0;
		if (decZone == `SZBT_Z_RAM || decZone == `SZBT_Z_NONE) begin
			decPost = 1'b0;
		end else if (decZone == `SZBT_Z_PERIPH) begin
			decWaits = `SZBT_PER_WAITS;
			decIdle = `SZBT_PER_IDLE;
		end else if (decFast) begin
			// Fast read: single cycle; writes get one wait
			if (cpuWrite) begin
				decWaits = `SZBT_FWR_WAITS;
			end
		end else begin
			decWaits = {1'b0, decCfg[`SZBT_WAIT_MSB:`SZBT_WAIT_LSB]} + 4'h1;
			if (decZone == `SZBT_Z_FLASH && cpuWrite && earlyWrite_reg) begin
				decWaits = decWaits + 4'h1;
			end
			decHold = decCfg[`SZBT_HOLD_MSB:`SZBT_HOLD_LSB];
		end
		// On-chip targets keep their fixed timing, so zone-change idles skip them
		if (decZone != lastZone_reg && decZone != `SZBT_Z_PERIPH &&
		    decZone != `SZBT_Z_RAM && decZone != `SZBT_Z_NONE) begin
			if (decCfg[`SZBT_PRE_IDLE_BIT]) begin
				decIdle = decIdle + 2'h1;
			end
			if (prevPost_reg) begin
				decIdle = decIdle + 2'h1;
			end
		end
	end

	// ****************************************
	// Snapshot taken as a cycle starts
	// ****************************************
	// Held for the whole cycle so register writes never disturb it
	reg [2:0] snapZone_reg;
	reg       snapTwo_reg;
	reg       snapBurst_reg;
	reg       snapBurstWait_reg;
	reg [3:0] snapWaits_reg;
	reg [1:0] snapHold_reg;
	reg       snapPost_reg;
	reg       snapWide_reg;
	reg       second_reg;
	wire      start = state_reg[0] && cpuReq;

	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			snapZone_reg      <= `SZBT_Z_NONE;
			snapTwo_reg       <= 1'b0;
			snapBurst_reg     <= 1'b0;
			snapBurstWait_reg <= 1'b0;
			snapWaits_reg     <= 4'h0;
			snapHold_reg      <= 2'h0;
			snapPost_reg      <= 1'b0;
			snapWide_reg      <= 1'b1;
		end else if (start) begin
			snapZone_reg      <= decZone;
			snapTwo_reg       <= decTwo;
			snapBurst_reg     <= decBurst;
			snapBurstWait_reg <= decBurstWait;
			snapWaits_reg     <= decWaits;
			snapHold_reg      <= decHold;
			snapPost_reg      <= decPost;
			snapWide_reg      <= decWide;
		end
	end

	// ****************************************
	// Phase sequencer
	// ****************************************
	reg [5:0] afterWait;
	reg [3:0] afterWaitLoad;
	reg [5:0] afterAcc;
	reg [3:0] afterAccLoad;
	reg [5:0] afterBurst;
	reg [3:0] afterBurstLoad;
	reg [5:0] state_next;
	reg [3:0] load_next;
	reg       finish;
	wire      phaseLast;
	wire      needSecond = snapTwo_reg && !snapBurst_reg && !second_reg;

	always @* begin
		if (snapHold_reg != 2'h0) begin
			afterBurst = S_HOLD;
			afterBurstLoad = {2'h0, snapHold_reg};
		end else if (needSecond) begin
			afterBurst = S_ACC;
			afterBurstLoad = 4'h1;
		end else begin
			afterBurst = S_IDLE;
			afterBurstLoad = 4'h0;
		end
		if (snapBurst_reg) begin
			afterWait = S_BURST;
			afterWaitLoad = {3'h0, snapBurstWait_reg} + 4'h1;
		end else begin
			afterWait = afterBurst;
			afterWaitLoad = afterBurstLoad;
		end
		if (snapWaits_reg != 4'h0) begin
			afterAcc = S_WAIT;
			afterAccLoad = snapWaits_reg;
		end else begin
			afterAcc = afterWait;
			afterAccLoad = afterWaitLoad;
		end
	end

	always @* begin
		state_next = state_reg;
		load_next = 4'h0;
		finish = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (cpuReq) begin
					if (decIdle != 2'h0) begin
						state_next = S_PRE;
						load_next = {2'h0, decIdle};
					end else begin
						state_next = S_ACC;
						load_next = 4'h1;
					end
				end
			end
			S_PRE: begin
				if (phaseLast) begin
					state_next = S_ACC;
					load_next = 4'h1;
				end
			end
			S_ACC: begin
				if (phaseLast) begin
					state_next = afterAcc;
					load_next = afterAccLoad;
				end
			end
			S_WAIT: begin
				if (phaseLast) begin
					state_next = afterWait;
					load_next = afterWaitLoad;
				end
			end
			S_BURST: begin
				if (phaseLast) begin
					state_next = afterBurst;
					load_next = afterBurstLoad;
				end
			end
			S_HOLD: begin
				if (phaseLast) begin
					state_next = needSecond ? S_ACC : S_IDLE;
					load_next = needSecond ? 4'h1 : 4'h0;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
		finish = !state_reg[0] && state_next == S_IDLE;
	end

	szbt_cycle_counter #(
		.WIDTH (4)
	) phaseCounter (
		.clk_sys   (clk_sys),
		.rstSync_n (rstSync_n),
		.load      (state_next != state_reg || (state_reg == S_ACC && phaseLast)),
		.loadValue (load_next),
		.last      (phaseLast)
	);

	// ****************************************
	// Sequencer state and outputs
	// ****************************************
	reg  doneOut_reg;
	reg  zone1Out_reg;
	reg  zone2Out_reg;
	reg  wideOut_reg;
	wire nextActive = !state_next[0] && !state_next[1];
	wire [2:0] nextZone = start ? decZone : snapZone_reg;

	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_reg    <= S_IDLE;
			second_reg   <= 1'b0;
			lastZone_reg <= `SZBT_Z_NONE;
			prevPost_reg <= 1'b0;
			doneOut_reg  <= 1'b0;
			zone1Out_reg <= 1'b0;
			zone2Out_reg <= 1'b0;
			wideOut_reg  <= 1'b1;
		end else begin
			state_reg   <= state_next;
			doneOut_reg <= finish;
			if (start) begin
				second_reg <= 1'b0;
			end else if (state_reg == S_HOLD || state_reg == S_WAIT ||
			             state_reg == S_ACC || state_reg == S_BURST) begin
				if (state_next == S_ACC && state_reg != S_ACC) begin
					second_reg <= 1'b1;
				end else if (state_reg == S_ACC && phaseLast && afterAcc == S_ACC) begin
					second_reg <= 1'b1;
				end
			end
			if (finish) begin
				lastZone_reg <= snapZone_reg;
				prevPost_reg <= snapPost_reg;
			end
			zone1Out_reg <= nextActive && nextZone == `SZBT_Z_ONE;
			zone2Out_reg <= nextActive && nextZone == `SZBT_Z_TWO;
			wideOut_reg  <= start ? decWide : snapWide_reg;
		end
	end

	assign regRdData   = rdData_reg;
	assign cpuBusy     = !state_reg[0];
	assign cpuDone     = doneOut_reg;
	assign zone1Select = zone1Out_reg;
	assign zone2Select = zone2Out_reg;
	assign busWidth16  = wideOut_reg;
	assign phaseIdle   = state_reg[1];
	assign phaseAccess = state_reg[2];
	assign phaseWait   = state_reg[3];
	assign phaseBurst  = state_reg[4];
	assign phaseHold   = state_reg[5];

endmodule

// ### testbench/szbt_bus_timing_asserts.sv
// Concurrent checks on the ports of the bus timing sequencer.
// Assumes a bind onto szbt_bus_timing; single clock domain.
`timescale 1ns/1ps

module szbt_bus_timing_asserts (
	// Clock and reset
	input logic        clk_sys,
	input logic        rst_n,
	// Register port
	input logic        regRead,
	input logic [15:0] regRdData,
	// CPU bus
	input logic        cpuReq,
	input logic [23:0] cpuAddr,
	input logic        cpuBusy,
	input logic        cpuDone,
	// Selects and phases
	input logic        zone1Select,
	input logic        zone2Select,
	input logic        phaseIdle,
	input logic        phaseAccess,
	input logic        phaseWait,
	input logic        phaseBurst,
	input logic        phaseHold
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	wire take   = cpuReq && !cpuBusy;
	wire ramHit = (cpuAddr >= 24'h0E8000 && cpuAddr <= 24'h0E91FF)
		|| (cpuAddr >= 24'h0EC000 && cpuAddr <= 24'h0EEBFF);
	wire perHit = (cpuAddr >= 24'h0EF000 && cpuAddr <= 24'h0EF1FF)
		|| (cpuAddr >= 24'hFF0000 && cpuAddr < 24'hFFFB00);

	property p_rd_quiet;
		!$past(regRead) |-> regRdData == 16'h0000;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
	property p_sel_excl;
		!(zone1Select && zone2Select);
	endproperty
	a_sel_excl: assert property (p_sel_excl) else $error("two zone selects at once");
	property p_sel_phase;
		(zone1Select || zone2Select) |-> (phaseAccess || phaseWait || phaseBurst || phaseHold);
	endproperty
	a_sel_phase: assert property (p_sel_phase) else $error("select during idle phase");
	property p_ram_single;
		take && ramHit |=> phaseAccess ##1 cpuDone;
	endproperty
	a_ram_single: assert property (p_ram_single) else $error("RAM access not single cycle");
	property p_per_timing;
		take && perHit |=> phaseIdle ##1 phaseAccess ##1 phaseWait ##1 cpuDone;
	endproperty
	a_per_timing: assert property (p_per_timing) else $error("peripheral timing wrong");
	property p_hold_max;
		phaseHold [*3] |=> !phaseHold;
	endproperty
	a_hold_max: assert property (p_hold_max) else $error("more than three holds");
	property p_wait_max;
		phaseWait [*8] ##1 phaseWait |=> !phaseWait;
	endproperty
	a_wait_max: assert property (p_wait_max) else $error("more than nine waits");
	property p_idle_max;
		phaseIdle && cpuBusy ##1 phaseIdle && cpuBusy |=> !phaseIdle;
	endproperty
	a_idle_max: assert property (p_idle_max) else $error("more than two idles");
	property p_busy_end;
		$fell(cpuBusy) |-> cpuDone;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy dropped without done");
	property p_done_pulse;
		cpuDone |=> !cpuDone;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
endmodule

// ### testbench/szbt_ext_mem.sv
// Far-side memory model: measures how long each zone select stands.
// Assumes registered selects sampled on the rising system clock.
`timescale 1ns/1ps

module szbt_ext_mem (
	// Clock
	input  logic       clk_sys,
	// Selects from the block
	input  logic       zone1Select,
	input  logic       zone2Select,
	// Observations for the bench
	output logic [1:0] lastSel,
	output logic [7:0] selCycles
);
	logic prevSel = 1'b0;

	initial lastSel = 2'h0;
	initial selCycles = 8'h00;

	// Counts the strobe of one access so a select held too long shows
	always @(posedge clk_sys) begin
		if (zone1Select || zone2Select) begin
			selCycles <= prevSel ? selCycles + 8'h01 : 8'h01;
			lastSel <= {zone2Select, zone1Select};
		end
		prevSel <= zone1Select || zone2Select;
	end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the static zone bus timing sequencer.
// Assumes the register port and CPU request handshake of the block.
`timescale 1ns/1ps

module tb;
	logic        clk_sys, rst_n, regWrite, regRead, cpuReq, cpuWrite, cpuWord;
	logic [2:0]  regAddr;
	logic [15:0] regWrData;
	logic [23:0] cpuAddr;
	wire  [15:0] regRdData;
	wire         cpuBusy, cpuDone, zone1Select, zone2Select, busWidth16;
	wire         phaseIdle, phaseAccess, phaseWait, phaseBurst, phaseHold;
	wire  [1:0]  lastSel;
	wire  [7:0]  selCycles;
	int          err_total, checks;

	szbt_bus_timing dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .cpuReq(cpuReq), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
		.cpuWord(cpuWord), .cpuBusy(cpuBusy), .cpuDone(cpuDone),
		.zone1Select(zone1Select), .zone2Select(zone2Select), .busWidth16(busWidth16),
		.phaseIdle(phaseIdle), .phaseAccess(phaseAccess), .phaseWait(phaseWait),
		.phaseBurst(phaseBurst), .phaseHold(phaseHold));
	szbt_ext_mem mem (.clk_sys(clk_sys), .zone1Select(zone1Select),
		.zone2Select(zone2Select), .lastSel(lastSel), .selCycles(selCycles));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic conclude;
		$display("checks=%0d errors=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic regWr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask

	task automatic regRd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		chk(regRdData, exp, "register read");
	endtask

	// Exp counts edges from the take edge to done, both counted; zero skips it
	task automatic cpuAcc(input logic [23:0] a, input logic wr, input logic wd,
		input logic [15:0] exp);
		int n;
		@(posedge clk_sys);
		cpuReq <= 1'b1;
		cpuAddr <= a;
		cpuWrite <= wr;
		cpuWord <= wd;
		@(posedge clk_sys);
		cpuReq <= 1'b0;
		n = 1;
		do begin
			@(posedge clk_sys);
			n++;
			#1;
		end while (cpuDone !== 1'b1 && n < 40);
		if (n >= 40) begin
			err_total++;
			$display("MISMATCH t=%0t bus cycle never completed", $time);
			conclude();
		end else if (exp != 16'h0000) begin
			chk(16'(n), exp, "cycle count");
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic tRegs;
		for (int i = 0; i < 4; i++)
			regRd(3'(i), 16'h069F);
		regRd(3'h4, 16'h0000);
		regWr(3'h2, 16'hFFFF);
		regRd(3'h2, 16'h0EFF);
		regRd(3'h6, 16'h0000);
		regWr(3'h2, 16'h069F);
	endtask

	task automatic tWaitHold;
		cpuAcc(24'h800010, 1'b0, 1'b1, 16'h0000);
		for (int w = 0; w < 8; w++) begin
			regWr(3'h2, 16'h0680 | 16'(w + 8 * (w % 4)));
			cpuAcc(24'h800000, w[0], 1'b1, 16'(w + (w % 4) + 3));
		end
	endtask

	task automatic tFastBurst;
		regWr(3'h2, 16'h0E9F);
		cpuAcc(24'h800000, 1'b0, 1'b1, 16'h0002);
		cpuAcc(24'h800000, 1'b1, 1'b1, 16'h0003);
		regWr(3'h2, 16'h0E1F);
		cpuAcc(24'h800000, 1'b0, 1'b1, 16'h0003);
		regWr(3'h2, 16'h0621);
		cpuAcc(24'h800000, 1'b0, 1'b1, 16'h0005);
		cpuAcc(24'h800000, 1'b0, 1'b0, 16'h0004);
		chk({15'h0000, busWidth16}, 16'h0000, "bus width");
		regWr(3'h2, 16'h0661);
		cpuAcc(24'h800000, 1'b0, 1'b1, 16'h0006);
		regWr(3'h2, 16'h0641);
		cpuAcc(24'h800000, 1'b0, 1'b1, 16'h0007);
	endtask

	task automatic tIdle;
		logic [15:0] z2t [4] = '{16'h0680, 16'h0080, 16'h0280, 16'h0080};
		logic [15:0] z1t [4] = '{16'h069F, 16'h009F, 16'h009F, 16'h049F};
		logic [15:0] ex [4] = '{16'h000F, 16'h000D, 16'h000E, 16'h000E};
		for (int r = 0; r < 4; r++) begin
			regWr(3'h2, z2t[r]);
			regWr(3'h1, z1t[r]);
			cpuAcc(24'h800000, 1'b0, 1'b1, 16'h0000);
			chk({8'h00, selCycles}, 16'h0002, "zone two strobe");
			chk({14'h0000, lastSel}, 16'h0002, "zone two select");
			cpuAcc(24'h100000, 1'b0, 1'b1, ex[r]);
			chk({8'h00, selCycles}, 16'h000C, "zone one strobe");
			chk({14'h0000, lastSel}, 16'h0001, "zone one select");
		end
	endtask

	task automatic tFlash;
		cpuAcc(24'h000100, 1'b0, 1'b1, 16'h0000);
		cpuAcc(24'h000100, 1'b0, 1'b1, 16'h000D);
		chk({15'h0000, busWidth16}, 16'h0001, "flash width");
		cpuAcc(24'h000100, 1'b1, 1'b1, 16'h000D);
		regWr(3'h4, 16'h0001);
		cpuAcc(24'h000100, 1'b1, 1'b1, 16'h000E);
		regWr(3'h4, 16'h0000);
		cpuAcc(24'h0E0000, 1'b0, 1'b1, 16'h000D);
		regWr(3'h0, 16'h0E9F);
		cpuAcc(24'h03FFFE, 1'b0, 1'b1, 16'h0002);
		cpuAcc(24'h03FFFE, 1'b1, 1'b1, 16'h0003);
		regWr(3'h0, 16'h069F);
	endtask

	task automatic tOnChip;
		cpuAcc(24'h0E8000, 1'b0, 1'b1, 16'h0002);
		cpuAcc(24'h0EEBFF, 1'b1, 1'b0, 16'h0002);
		cpuAcc(24'h0EF000, 1'b0, 1'b1, 16'h0000);
		cpuAcc(24'h0EF1FE, 1'b1, 1'b1, 16'h0004);
		cpuAcc(24'hFF0000, 1'b0, 1'b1, 16'h0004);
		regWr(3'h3, 16'h0091);
		cpuAcc(24'hFFFB00, 1'b0, 1'b1, 16'h0000);
		cpuAcc(24'hFFFBFE, 1'b0, 1'b1, 16'h0006);
	endtask

	// Rewrite lands mid-cycle; the running cycle keeps its snapshot
	task automatic tLateWrite;
		regWr(3'h2, 16'h0687);
		cpuAcc(24'h800000, 1'b0, 1'b1, 16'h0000);
		fork
			cpuAcc(24'h800000, 1'b0, 1'b1, 16'h000A);
			begin
				repeat (4) @(posedge clk_sys);
				regWr(3'h2, 16'h0680);
			end
		join
		cpuAcc(24'h800000, 1'b0, 1'b1, 16'h0003);
	endtask

	initial begin
		rst_n = 1'b0;
		{regWrite, regRead, cpuReq, cpuWrite, cpuWord} = 5'h00;
		regAddr = 3'h0;
		regWrData = 16'h0000;
		cpuAddr = 24'h000000;
		err_total = 0;
		checks = 0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		tRegs();
		tWaitHold();
		tFastBurst();
		tIdle();
		tFlash();
		tOnChip();
		tLateWrite();
		conclude();
	end
endmodule

bind szbt_bus_timing szbt_bus_timing_asserts chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.regRead(regRead), .regRdData(regRdData), .cpuReq(cpuReq), .cpuAddr(cpuAddr),
	.cpuBusy(cpuBusy), .cpuDone(cpuDone), .zone1Select(zone1Select),
	.zone2Select(zone2Select), .phaseIdle(phaseIdle), .phaseAccess(phaseAccess),
	.phaseWait(phaseWait), .phaseBurst(phaseBurst), .phaseHold(phaseHold));
